// [hw/adcx_ext_ctrl.sv]
/*
 * Extended analog input controller: Avalon-MM register file, result
 * storage, reference ladder control and interrupt logic around the
 * conversion sequencer.
 * Assumes the analog core is synchronous to clock and answers each
 * conversion request with a one-cycle done pulse and 10-bit data.
 */
// The placing of the registers and the Avalon-MM slave port were decided locally.
module adcx_ext_ctrl
  import adcx_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Analog core
  output logic             convReq,
  output logic      [3:0]  convSrc,
  input  wire logic        convDone,
  input  wire logic [9:0]  convData,
  // Amplifier routing and references
  output logic             ampRouteEn,
  output logic      [2:0]  ampRouteCh,
  output logic             ladderConnect,
  output logic             dacRefConnect,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic [2:0]       mode;
    logic [2:0]       chan;
    logic             start;
    logic [1:0]       extSel;
    logic             res10;
    logic             ladder;
    logic [1:0]       pinGroup;
    logic             dmaUse;
    logic             multiSweep;
    logic [1:0]       irqStat;
    logic [1:0]       irqMask;
    logic [7:0][9:0]  result;
    logic             waitReq;
    logic [31:0]      rdata;
    logic             irq;
    logic             dacRef;
  } adcx_top_s;

  adcx_top_s  s_q;
  adcx_top_s  s_d;
  adcx_seq_if sif ();

  adcx_seq u_seq (
    .clock (clock),
    .rst_b (rst_b),
    .sif   (sif.seq)
  );

  // Extended inputs only in one-shot and repeat
  // Relies on pin group 00 and no multi sweep
  assign sif.extSel   = ((s_q.mode == MODE_ONE_SHOT ||
                          s_q.mode == MODE_REPEAT) &&
                         s_q.pinGroup == 2'h0 && !s_q.multiSweep)
                        ? s_q.extSel : EXT_NONE;
  assign sif.start    = s_q.start;
  assign sif.mode     = s_q.mode;
  assign sif.chan     = s_q.chan;
  assign sif.dmaUse   = s_q.dmaUse;
  assign sif.convDone = convDone;

  always_comb begin
    logic [31:0] bm;
    logic [31:0] rv;
    logic [31:0] wv;
    logic [31:0] w1c;
    logic        wrHit;
    logic        done;
    bm    = {{8{byteenable[3]}}, {8{byteenable[2]}},
             {8{byteenable[1]}}, {8{byteenable[0]}}};
    rv    = 32'h0000_0000;
    wv    = 32'h0000_0000;
    w1c   = 32'h0000_0000;
    wrHit = write && !s_q.waitReq;
    done  = sif.convReq && convDone;
    s_d   = s_q;

    // Readback of the addressed register
    if (address[7:5] == OFS_RESULT0[7:5]) begin
      rv[9:0] = s_q.result[address[4:2]];
    end else begin
      unique case ({address[7:2], 2'b00})
        OFS_CTRL0: begin
          rv[CTL0_MODE_LSB +: 3] = s_q.mode;
          rv[CTL0_CHAN_LSB +: 3] = s_q.chan;
          rv[CTL0_START_BIT]     = s_q.start;
        end
        OFS_CTRL1: begin
          rv[CTL1_SEL_LO]  = s_q.extSel[0];
          rv[CTL1_SEL_HI]  = s_q.extSel[1];
          rv[CTL1_RES_BIT] = s_q.res10;
          rv[CTL1_LADDER]  = s_q.ladder;
        end
        OFS_CTRL2: begin
          rv[CTL2_PGS_LO] = s_q.pinGroup[0];
          rv[CTL2_PGS_HI] = s_q.pinGroup[1];
        end
        OFS_CTRL3: begin
          rv[CTL3_DMA_BIT] = s_q.dmaUse;
          rv[CTL3_MSS_BIT] = s_q.multiSweep;
        end
        OFS_IRQ_STATUS: rv[1:0] = s_q.irqStat;
        OFS_IRQ_MASK:   rv[1:0] = s_q.irqMask;
        OFS_STATUS: begin
          rv[STAT_BUSY_BIT]     = sif.busy;
          rv[STAT_SRC_LSB +: 4] = sif.convSrc;
        end
        default: rv = 32'h0000_0000;
      endcase
    end
    wv  = (rv & ~bm) | (writedata & bm);
    w1c = writedata & bm;

    // Bus handshake: two edges from request to completion
    s_d.waitReq = 1'b1;
    if ((read || write) && s_q.waitReq) begin
      s_d.waitReq = 1'b0;
      if (read) begin
        s_d.rdata = rv;
      end
    end

    // Hardware ends one-shot and single sweep runs
    if (sif.seqDone) begin
      s_d.start = 1'b0;
    end

    if (wrHit) begin
      unique case ({address[7:2], 2'b00})
        OFS_CTRL0: begin
          s_d.mode  = wv[CTL0_MODE_LSB +: 3];
          s_d.chan  = wv[CTL0_CHAN_LSB +: 3];
          // Software set wins over the hardware clear
          s_d.start = wv[CTL0_START_BIT];
        end
        OFS_CTRL1: begin
          s_d.extSel = {wv[CTL1_SEL_HI], wv[CTL1_SEL_LO]};
          s_d.res10  = wv[CTL1_RES_BIT];
          s_d.ladder = wv[CTL1_LADDER];
        end
        OFS_CTRL2: begin
          s_d.pinGroup = {wv[CTL2_PGS_HI], wv[CTL2_PGS_LO]};
        end
        OFS_CTRL3: begin
          s_d.dmaUse     = wv[CTL3_DMA_BIT];
          s_d.multiSweep = wv[CTL3_MSS_BIT];
        end
        OFS_IRQ_STATUS: s_d.irqStat = s_q.irqStat & ~w1c[1:0];
        OFS_IRQ_MASK:   s_d.irqMask = wv[1:0];
        default: s_d.mode = s_q.mode;
      endcase
    end

    if (done) begin
      s_d.result[sif.storeIdx] = s_q.res10 ? convData
                                           : {2'b00, convData[9:2]};
    end

    // Completion sets the flag, set beats clear
    if (done) begin
      s_d.irqStat[IRQ_CONV_BIT] = 1'b1;
    end
    if (sif.seqDone) begin
      s_d.irqStat[IRQ_SEQ_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.irqStat & s_d.irqMask);

    s_d.dacRef = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q            <= '0;
      s_q.mode       <= RST_MODE;
      s_q.chan       <= RST_CHAN;
      s_q.extSel     <= RST_SEL;
      s_q.pinGroup   <= RST_PGS;
      s_q.irqStat    <= RST_IRQ;
      s_q.irqMask    <= RST_IRQ;
      s_q.ladder     <= RST_LADDER;
      s_q.res10      <= RST_RES10;
      s_q.dacRef     <= RST_DAC_REF;
      s_q.waitReq    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata      = s_q.rdata;
  assign waitrequest   = s_q.waitReq;
  assign irq           = s_q.irq;
  assign ladderConnect = s_q.ladder;
  assign dacRefConnect = s_q.dacRef;
  assign convReq       = sif.convReq;
  assign convSrc       = sif.convSrc;
  assign ampRouteEn    = sif.routeEn;
  assign ampRouteCh    = sif.routeCh;

endmodule : adcx_ext_ctrl

// [common/adcx_pkg.sv]
/*
 * Constants, field positions, reset values and types shared by the
 * extended analog input controller and its conversion sequencer.
 * Assumes a single 20 MHz clock and a 32-bit Avalon-MM register bus
 * with byte addresses.
 */
package adcx_pkg;

  // Clock and amplifier settling
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned AMP_SETTLE_NS  = 1000;
  localparam int unsigned AMP_SETTLE_CYC =
    (AMP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [4:0]  AMP_SETTLE_CNT = 5'(AMP_SETTLE_CYC);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0      = 8'h00;
  localparam logic [7:0] OFS_CTRL1      = 8'h04;
  localparam logic [7:0] OFS_CTRL2      = 8'h08;
  localparam logic [7:0] OFS_CTRL3      = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_RESULT0    = 8'h20;

  // Field positions
  localparam int CTL0_MODE_LSB  = 0;
  localparam int CTL0_CHAN_LSB  = 3;
  localparam int CTL0_START_BIT = 6;
  localparam int CTL1_SEL_LO    = 0;
  localparam int CTL1_SEL_HI    = 1;
  localparam int CTL1_RES_BIT   = 2;
  localparam int CTL1_LADDER    = 3;
  localparam int CTL2_PGS_LO    = 0;
  localparam int CTL2_PGS_HI    = 1;
  localparam int CTL3_DMA_BIT   = 0;
  localparam int CTL3_MSS_BIT   = 1;
  localparam int IRQ_CONV_BIT   = 0;
  localparam int IRQ_SEQ_BIT    = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SRC_LSB   = 4;

  // Reset values
  localparam logic [2:0] RST_MODE     = 3'h0;
  localparam logic [2:0] RST_CHAN     = 3'h0;
  localparam logic [1:0] RST_SEL      = 2'h0;
  localparam logic [1:0] RST_PGS      = 2'h0;
  localparam logic [1:0] RST_IRQ      = 2'h0;
  localparam logic       RST_LADDER   = 1'b0;
  localparam logic       RST_RES10    = 1'b0;
  localparam logic       RST_DAC_REF  = 1'b1;

  // Converter source codes
  localparam logic [3:0] SRC_EXT_A = 4'h8;
  localparam logic [3:0] SRC_EXT_B = 4'h9;

  typedef enum logic [2:0] {
    MODE_ONE_SHOT     = 3'h0,
    MODE_REPEAT       = 3'h1,
    MODE_SINGLE_SWEEP = 3'h2,
    MODE_REPEAT_SWEEP = 3'h3
  } adcx_mode_e;

  typedef enum logic [1:0] {
    EXT_NONE  = 2'h0,
    EXT_PIN_A = 2'h1,
    EXT_PIN_B = 2'h2,
    EXT_AMP   = 2'h3
  } adcx_extsel_e;

  typedef enum logic [3:0] {
    SQ_IDLE    = 4'b0001,
    SQ_SETUP   = 4'b0010,
    SQ_SETTLE  = 4'b0100,
    SQ_CONVERT = 4'b1000
  } adcx_seq_state_e;

endpackage : adcx_pkg

// [common/adcx_seq_if.sv]
/*
 * Link between the register side and the conversion sequencer.
 * Assumes both ends run on the same clock.
 */
interface adcx_seq_if;
  import adcx_pkg::*;

  logic       start;
  logic [2:0] mode;
  logic [2:0] chan;
  logic [1:0] extSel;
  logic       dmaUse;
  logic       convDone;
  logic       convReq;
  logic [3:0] convSrc;
  logic       routeEn;
  logic [2:0] routeCh;
  logic [2:0] storeIdx;
  logic       seqDone;
  logic       busy;

  modport ctrl (
    output start, mode, chan, extSel, dmaUse, convDone,
    input  convReq, convSrc, routeEn, routeCh, storeIdx, seqDone, busy
  );

  modport seq (
    input  start, mode, chan, extSel, dmaUse, convDone,
    output convReq, convSrc, routeEn, routeCh, storeIdx, seqDone, busy
  );

endinterface : adcx_seq_if

// [hw/adcx_seq.sv]
/*
 * Conversion sequencer: walks channels in mode order, picks the
 * converter source and the result slot, times amplifier settling.
 * Assumes the analog core answers each request with one done pulse.
 */
module adcx_seq
  import adcx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register side
  adcx_seq_if.seq  sif
);

  typedef struct packed {
    adcx_seq_state_e state;
    logic [2:0]      idx;
    logic [4:0]      cnt;
    logic            convReq;
    logic [3:0]      convSrc;
    logic            routeEn;
    logic [2:0]      routeCh;
    logic [2:0]      storeIdx;
    logic            seqDone;
  } adcx_seq_s;

  adcx_seq_s s_q;
  adcx_seq_s s_d;

  always_comb begin
    s_d         = s_q;
    s_d.seqDone = 1'b0;
    unique case (s_q.state)
      SQ_IDLE: begin
        // Done pulse of a finished run must not restart it
        if (sif.start && !s_q.seqDone) begin
          s_d.idx   = (sif.mode == MODE_SINGLE_SWEEP ||
                       sif.mode == MODE_REPEAT_SWEEP) ? 3'h0 : sif.chan;
          s_d.state = SQ_SETUP;
        end
      end
      SQ_SETUP: begin
        s_d.routeEn = 1'b0;
        s_d.state   = SQ_CONVERT;
        s_d.convReq = 1'b1;
        unique case (sif.extSel)
          EXT_PIN_A: begin
            s_d.convSrc  = SRC_EXT_A;
            s_d.storeIdx = 3'h0;
          end
          EXT_PIN_B: begin
            s_d.convSrc  = SRC_EXT_B;
            // Pin B slot, DMA folds it
            s_d.storeIdx = sif.dmaUse ? 3'h0 : 3'h1;
          end
          EXT_AMP: begin
            s_d.routeEn  = 1'b1;
            s_d.routeCh  = s_q.idx;
            s_d.convSrc  = SRC_EXT_B;
            s_d.storeIdx = sif.dmaUse ? 3'h0 : s_q.idx;
            s_d.cnt      = AMP_SETTLE_CNT;
            s_d.convReq  = 1'b0;
            s_d.state    = SQ_SETTLE;
          end
          default: begin
            s_d.convSrc  = {1'b0, s_q.idx};
            s_d.storeIdx = sif.dmaUse ? 3'h0 : s_q.idx;
          end
        endcase
      end
      SQ_SETTLE: begin
        // External amplifier response is slow; wait before sampling
        if (s_q.cnt <= 5'h01) begin
          s_d.convReq = 1'b1;
          s_d.state   = SQ_CONVERT;
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      SQ_CONVERT: begin
        if (sif.convDone) begin
          s_d.convReq = 1'b0;
          s_d.state   = SQ_SETUP;
          unique case (sif.mode)
            MODE_REPEAT: s_d.idx = s_q.idx;
            MODE_SINGLE_SWEEP: begin
              s_d.idx = s_q.idx + 3'h1;
              if (s_q.idx == 3'h7) begin
                s_d.seqDone = 1'b1;
                s_d.routeEn = 1'b0;
                s_d.state   = SQ_IDLE;
              end
            end
            MODE_REPEAT_SWEEP: s_d.idx = s_q.idx + 3'h1;
            default: begin
              s_d.seqDone = 1'b1;
              s_d.routeEn = 1'b0;
              s_d.state   = SQ_IDLE;
            end
          endcase
        end
      end
      default: s_d.state = SQ_IDLE;
    endcase
    // Stop aborts whatever is in flight
    if (!sif.start && s_q.state != SQ_IDLE) begin
      s_d.state   = SQ_IDLE;
      s_d.convReq = 1'b0;
      s_d.routeEn = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{state: SQ_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.convReq  = s_q.convReq;
  assign sif.convSrc  = s_q.convSrc;
  assign sif.routeEn  = s_q.routeEn;
  assign sif.routeCh  = s_q.routeCh;
  assign sif.storeIdx = s_q.storeIdx;
  assign sif.seqDone  = s_q.seqDone;
  assign sif.busy     = (s_q.state != SQ_IDLE);

endmodule : adcx_seq

// [testbench/adcx_core_model.sv]
/*
 * Behavioural analog core: answers each conversion request with one
 * done pulse after a programmable delay.
 * Assumes requests come from the controller on the same clock.
 */
module adcx_core_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Request side
  input  wire logic       convReq,
  input  wire logic [3:0] convSrc,
  input  wire logic [3:0] delay,
  // Answer side
  output logic            convDone,
  output logic      [9:0] convData
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt;

  // Data marks its source; off the pulse the lines show the inverse
  assign convData = convDone ? {convSrc, 6'h2D} : ~{convSrc, 6'h2D};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 4'h0;
      convDone <= 1'h0;
    end else if (convReq && !convDone && cnt == delay) begin
      cnt      <= 4'h0;
      convDone <= 1'h1;
    end else begin
      cnt      <= (convReq && !convDone) ? cnt + 4'h1 : 4'h0;
      convDone <= 1'h0;
    end
  end
endmodule : adcx_core_model

// [testbench/adcx_ext_ctrl_assertions.sv]
/*
 * Port-level checker for the extended analog input controller.
 * Assumes it is bound to the controller's top module.
 */
module adcx_ext_ctrl_assertions
  import adcx_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  // Core and pins
  input wire logic        convReq,
  input wire logic [3:0]  convSrc,
  input wire logic        convDone,
  input wire logic        ampRouteEn,
  input wire logic [2:0]  ampRouteCh,
  input wire logic        ladderConnect,
  input wire logic        dacRefConnect,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic       ctl1Wr;
  logic [2:0] evHist;
  assign ctl1Wr = write && !waitrequest && byteenable[0] &&
                  address[7:2] == OFS_CTRL1[7:2];

  // Irq may only rise shortly after a completion or a register write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) evHist <= 3'h0;
    else evHist <= {evHist[1:0], (convReq && convDone) ||
                    (write && !waitrequest)};
  end

  sequence bus_take;   (read || write) && waitrequest; endsequence
  sequence bus_answer; !waitrequest ##1 waitrequest;   endsequence

  property p_src_held;
    convReq && !convDone |=> $stable(convSrc);
  endproperty
  property p_amp_pin_b;
    ampRouteEn && convReq |-> convSrc == SRC_EXT_B;
  endproperty
  property p_route_steady;
    ampRouteEn && convReq && $past(convReq) |-> $stable(ampRouteCh);
  endproperty
  property p_ladder_follows;
    ctl1Wr |=> ladderConnect == $past(writedata[3]);
  endproperty
  property p_ladder_only_wr;
    !ctl1Wr |=> $stable(ladderConnect);
  endproperty

  a_bus_one_wait: assert property (bus_take |=> bus_answer)
    else $error("bus answer not after one wait cycle");
  a_src_legal: assert property (convReq |-> convSrc <= SRC_EXT_B)
    else $error("converter source out of range");
  a_src_held: assert property (p_src_held)
    else $error("source changed during conversion");
  a_amp_pin_b: assert property (p_amp_pin_b)
    else $error("amplifier mode not sampling return pin");
  a_route_steady: assert property (p_route_steady)
    else $error("routed channel moved during conversion");
  a_irq_cause: assert property ($rose(irq) |-> |evHist)
    else $error("irq rose without a cause");
  a_ladder_follows: assert property (p_ladder_follows)
    else $error("ladder pin does not follow control bit");
  a_ladder_only_wr: assert property (p_ladder_only_wr)
    else $error("ladder pin changed without a write");
  a_dac_ref_on: assert property (dacRefConnect)
    else $error("converter reference output dropped");
  a_ladder_on_conv: assert property (convReq |-> ladderConnect)
    else $error("conversion requested with ladder cut");
endmodule : adcx_ext_ctrl_assertions

bind adcx_ext_ctrl adcx_ext_ctrl_assertions i_adcx_ext_ctrl_assertions (
  .clock, .rst_b, .address, .read, .write, .writedata, .byteenable,
  .waitrequest, .convReq, .convSrc, .convDone, .ampRouteEn, .ampRouteCh,
  .ladderConnect, .dacRefConnect, .irq);

// [testbench/adcx_ext_ctrl_tb.sv]
/*
 * Self-checking bench for the extended analog input controller.
 * Assumes the core model and the bound checker are compiled first.
 */
module adcx_ext_ctrl_tb
  import adcx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [2:0] mode, chan;
    logic [1:0] sel;
    logic       res, dma;
    logic [1:0] pgs, mask;
    logic [2:0] idx;
    logic [3:0] src;
    logic       rte;
    logic [9:0] val;
  } adcx_row_s;

  logic        clock = 1'h0;
  logic        rst_b, read, write, waitrequest, convReq, convDone, irq;
  logic        ampRouteEn, ladderConnect, dacRefConnect;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, d;
  logic [3:0]  byteenable, convSrc, coreDelay, lastSrc, lastRte;
  logic [9:0]  convData;
  logic [2:0]  ampRouteCh;
  int          mismatches, comparisons;

  // mode chan sel res dma pgs mask idx src rte val
  adcx_row_s rows [9] = '{
    '{3'h0,3'h0,2'h1,1'h1,1'h0,2'h0,2'h1,3'h0,4'h8,1'h0,10'h22D},
    '{3'h0,3'h0,2'h2,1'h1,1'h0,2'h0,2'h1,3'h1,4'h9,1'h0,10'h26D},
    '{3'h0,3'h0,2'h2,1'h1,1'h1,2'h0,2'h1,3'h0,4'h9,1'h0,10'h26D},
    '{3'h0,3'h0,2'h1,1'h0,1'h0,2'h0,2'h1,3'h0,4'h8,1'h0,10'h08B},
    '{3'h0,3'h5,2'h3,1'h1,1'h0,2'h0,2'h1,3'h5,4'h9,1'h1,10'h26D},
    '{3'h0,3'h3,2'h0,1'h1,1'h0,2'h0,2'h1,3'h3,4'h3,1'h0,10'h0ED},
    '{3'h0,3'h2,2'h1,1'h1,1'h0,2'h1,2'h1,3'h2,4'h2,1'h0,10'h0AD},
    '{3'h1,3'h0,2'h1,1'h1,1'h0,2'h0,2'h1,3'h0,4'h8,1'h0,10'h22D},
    '{3'h2,3'h0,2'h1,1'h1,1'h0,2'h0,2'h2,3'h7,4'h7,1'h0,10'h1ED}};

  adcx_ext_ctrl i_adcx_ext_ctrl (.clock, .rst_b, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .convReq,
    .convSrc, .convDone, .convData, .ampRouteEn, .ampRouteCh,
    .ladderConnect, .dacRefConnect, .irq);
  adcx_core_model i_adcx_core_model (.clock, .rst_b, .convReq, .convSrc,
    .delay(coreDelay), .convDone, .convData);

  always #25 clock = ~clock;

  always @(posedge clock) begin
    if (convReq === 1'h1) begin
      lastSrc <= convSrc;
      lastRte <= {ampRouteEn, ampRouteCh};
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    address   <= a;
    writedata <= wd;
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'h0 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1, "bus hang");
    rd = readdata;
    read  <= 1'h0;
    write <= 1'h0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] t;
    bus(1'h1, a, v, t);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'h0, a, 32'h0, v);
  endtask : rd

  task automatic run_row(input int i);
    adcx_row_s r;
    r = rows[i];
    coreDelay <= 4'(i % 3);
    wr(OFS_CTRL2, {30'h0, r.pgs});
    wr(OFS_CTRL3, {31'h0, r.dma});
    wr(OFS_IRQ_MASK, {30'h0, r.mask});
    wr(OFS_CTRL1, {29'h1, r.res, r.sel});
    wr(OFS_CTRL0, {26'h1, r.chan, r.mode});
    for (int n = 0; n < 600 && irq !== 1'h1; n++) @(posedge clock);
    chk({31'h0, irq}, 32'h1, "irq on completion");
    wr(OFS_CTRL0, 32'h0);
    rd(8'(OFS_RESULT0 + {r.idx, 2'h0}), d);
    chk(d, {22'h0, r.val}, "result slot");
    chk({28'h0, lastSrc}, {28'h0, r.src}, "source");
    chk({28'h0, lastRte[3] ? lastRte : 4'h0},
        {28'h0, r.rte, r.rte ? r.chan : 3'h0}, "route");
    wr(OFS_IRQ_STATUS, 32'h3);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("row %0d done", i);
  endtask : run_row

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (30000) @(posedge clock);
    chk(32'h0, 32'h1, "watchdog");
    close_out;
  end

  initial begin
    {read, write, address, writedata} = '0;
    byteenable = 4'hF;
    coreDelay  = 4'h0;
    rst_b      = 1'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    foreach (rows[i]) run_row(i);
    // Masked completion, then unmask and clear
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_CTRL0, 32'h48);
    d = 32'h0;
    for (int n = 0; n < 50 && d[0] !== 1'h1; n++) rd(OFS_IRQ_STATUS, d);
    chk(d & 32'h1, 32'h1, "status flag");
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(OFS_RESULT0, d);
    chk(d, 32'h22D, "pin A one-shot");
    wr(OFS_IRQ_MASK, 32'h1);
    @(posedge clock);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(OFS_IRQ_STATUS, 32'h1);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(OFS_CTRL1, 32'h0);
    chk({30'h0, ladderConnect, dacRefConnect}, 32'h1,
        "ladder cut");
    // Lanes off and an unmapped place
    byteenable <= 4'h0;
    wr(OFS_CTRL1, 32'hF);
    byteenable <= 4'hF;
    rd(OFS_CTRL1, d);
    chk(d, 32'h0, "lanes off");
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, d);
    chk(d, 32'h0, "unmapped");
    // Repeat sweep cycles until stopped, 8-bit storage
    wr(OFS_CTRL1, 32'h8);
    wr(OFS_CTRL0, 32'h43);
    repeat (100) @(posedge clock);
    rd(OFS_STATUS, d);
    chk(d & 32'h1, 32'h1, "sweep still busy");
    wr(OFS_CTRL0, 32'h0);
    rd(8'(OFS_RESULT0 + 8'h1C), d);
    chk(d, 32'h7B, "repeat sweep slot 7");
    // Reset during a repeat run
    wr(OFS_CTRL1, 32'h8);
    wr(OFS_CTRL0, 32'h41);
    repeat (3) @(posedge clock);
    rst_b <= 1'h0;
    @(posedge clock);
    chk({26'h0, convReq, ampRouteEn, ladderConnect, dacRefConnect, irq,
         waitrequest}, 32'h5, "reset outputs");
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    rd(OFS_CTRL1, d);
    chk(d, 32'h0, "reset value");
    $display("awkward cases done");
    close_out;
  end
endmodule : adcx_ext_ctrl_tb
